/* include/bbp_pkg.sv */
// Shared constants and types for the backplane block paging engine
`default_nettype none
package bbp_pkg;

  // ------------------------------------------------------------------
  // Image and database geometry
  // ------------------------------------------------------------------
  localparam int unsigned IMG_WORDS = 64;
  localparam int unsigned BLK_WORDS = 60;
  localparam int unsigned DB_WORDS  = 5000;
  localparam int unsigned DB_AW     = 13;
  localparam int unsigned UP_PAY_LO = 2;
  localparam int unsigned UP_PAY_HI = 61;
  localparam int unsigned DN_PAY_LO = 1;
  localparam int unsigned DN_PAY_HI = 60;
  localparam logic [15:0] ID_NULL   = 16'h0000;
  localparam logic [15:0] ID_STATUS = 16'hFFFF;

  // ------------------------------------------------------------------
  // Status block word positions
  // ------------------------------------------------------------------
  localparam logic [5:0] SW_SCAN   = 6'h02;
  localparam logic [5:0] SW_PROD_L = 6'h03;
  localparam logic [5:0] SW_PROD_H = 6'h04;
  localparam logic [5:0] SW_VER_L  = 6'h05;
  localparam logic [5:0] SW_VER_H  = 6'h06;
  localparam logic [5:0] SW_OS_L   = 6'h07;
  localparam logic [5:0] SW_OS_H   = 6'h08;
  localparam logic [5:0] SW_RUN_L  = 6'h09;
  localparam logic [5:0] SW_RUN_H  = 6'h0A;
  localparam logic [5:0] SW_P1_REQ = 6'h0B;
  localparam logic [5:0] SW_P1_RSP = 6'h0C;
  localparam logic [5:0] SW_P1_ERR = 6'h0D;
  localparam logic [5:0] SW_P1_TX  = 6'h0E;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned WAIT_TIME_US = 10;
  localparam int unsigned WAIT_CYC     = WAIT_TIME_US * CLK_MHZ;

  // ------------------------------------------------------------------
  // Register map and reset values
  // ------------------------------------------------------------------
  localparam logic [11:0] OFS_RD_START = 12'h000;
  localparam logic [11:0] OFS_RD_COUNT = 12'h004;
  localparam logic [11:0] OFS_WR_START = 12'h008;
  localparam logic [11:0] OFS_WR_COUNT = 12'h00C;
  localparam logic [11:0] OFS_CTRL     = 12'h010;
  localparam logic [11:0] OFS_SEQ      = 12'h014;
  localparam logic [11:0] OFS_SCAN     = 12'h018;
  localparam logic [15:0] RST_REGION   = 16'h0000;
  localparam logic        RST_ENABLE   = 1'b0;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        first;
    logic        last;
    logic [5:0]  idx;
    logic [15:0] data;
  } bbp_up_t;

  typedef struct packed {
    logic        valid;
    logic        first;
    logic [15:0] data;
  } bbp_dn_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] wr_id;
  } bbp_jump_t;

  typedef struct packed {
    logic             valid;
    logic [DB_AW-1:0] addr;
    logic [15:0]      data;
  } bbp_net_wr_t;

endpackage : bbp_pkg
`default_nettype wire

/* rtl/bbp_wrap_idx.sv */
// Ascending block index with wrap from the last block back to one
`default_nettype none
module bbp_wrap_idx (
  input  wire logic [15:0] cur,
  input  wire logic [15:0] lim,
  output logic      [15:0] nxt
);
  always_comb begin
    if (lim == 16'h0000) begin
      nxt = 16'h0000;
    end else if (cur >= lim) begin
      nxt = 16'h0001;
    end else begin
      nxt = cur + 16'h0001;
    end
  end
endmodule : bbp_wrap_idx
`default_nettype wire

/* rtl/bbp_evt_cnt.sv */
// Free-running 16-bit event counter
`default_nettype none
module bbp_evt_cnt (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        evt,
  output logic      [15:0] cnt
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
    end else if (evt) begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule : bbp_evt_cnt
`default_nettype wire

/* rtl/bbp_paging.sv */
// Backplane block paging engine with APB configuration
//
// Contract
// RULE_01: Read region out, write region in, continuously.
// RULE_02: Host keeps both regions inside user data.
// RULE_03: Regions split into 60-word indexed blocks.
// RULE_04: Input image: ids, 60 payload, spare.
// RULE_05: Output image: id, 60 payload, spare.
// RULE_06: Upload index places payload in host table.
// RULE_07: Download index selects database write location.
// RULE_08: Read and write indices step, wrap independently.
// RULE_09: Host id, network or debug alter sequence.
// RULE_10: Late host repeats same download request.
// RULE_11: Upload index zero is null block.
// RULE_12: Status block index -1 after last block.
// RULE_13: Status word 2 counts program cycles.
// RULE_14: Status words 3-10 carry identity fields.
// RULE_15: Status words 11-13 port 1 command counts.
// RULE_16: Status word 14 port 1 transmitted count.
// RULE_17: Host copies status block to file.
// RULE_18: Paging covers registers 0-4999 plus status.
// RULE_19: Network inbound data targets read region.
// RULE_20: Network outbound data from write region.
// RULE_21: Both images are exactly 64 words.
// RULE_22: Block ids are 16-bit two's complement.
//
// The register offsets and the APB slave port were chosen for this implementation.
`default_nettype none
module bbp_paging #(
  parameter logic [31:0] PRODUCT_CODE = 32'h0000_0A5A, // Arbitrary value
  parameter logic [31:0] SW_VERSION   = 32'h0000_0100,
  parameter logic [31:0] OS_DATE      = 32'h0000_0101,
  parameter logic [31:0] RUN_NUMBER   = 32'h0000_0001
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output bbp_pkg::bbp_up_t          up,
  input  wire bbp_pkg::bbp_dn_t     dn,
  input  wire bbp_pkg::bbp_jump_t   jump,
  input  wire bbp_pkg::bbp_net_wr_t net_wr,
  input  wire logic [12:0]          net_rd_addr,
  output logic      [15:0]          net_rd_data,
  input  wire logic [3:0]           p1_evt
);
  import bbp_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} bbp_state_t;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] blk_count(input logic [15:0] words);
    logic [16:0] tot;
    tot = 17'(words) + 17'(BLK_WORDS - 1);
    return 16'(tot / 17'(BLK_WORDS));
  endfunction : blk_count

  function automatic logic [16:0] blk_off(input logic [15:0] blk,
                                          input logic [5:0]  word);
    logic [22:0] prod;
    prod = 23'(blk - 16'h0001) * 23'(BLK_WORDS) + 23'(word);
    return prod[16:0];
  endfunction : blk_off

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [15:0]  db [0:DB_WORDS-1];
  logic [15:0]  rd_start_reg, rd_count_reg, wr_start_reg, wr_count_reg;
  logic         enable_reg;
  bbp_state_t   state_reg;
  logic [5:0]   up_cnt_reg;
  logic [11:0]  wait_cnt_reg;
  logic [15:0]  cur_rd_reg, wr_req_reg;
  logic         got_img_reg;
  logic [5:0]   dn_idx_reg;
  logic         dn_live_reg;
  logic [15:0]  dn_id_reg;
  logic         img_done_reg;
  logic [15:0]  nr_blk, nw_blk;
  logic [15:0]  wr_after_img, wr_first, rd_next;
  logic         send_end, timeout;
  logic [4:0]   evt_all;
  logic [15:0]  cnt [5];
  logic [15:0]  up_word;
  logic [16:0]  up_off, up_addr, dn_off, dn_addr;
  logic         dn_wr_en;

  assign nr_blk   = blk_count(rd_count_reg); // RULE_03
  assign nw_blk   = blk_count(wr_count_reg); // RULE_03
  assign send_end = (state_reg == ST_SEND) && (up_cnt_reg == 6'(IMG_WORDS-1));
  assign timeout  = (state_reg == ST_WAIT) && !got_img_reg &&
                    (wait_cnt_reg == 12'(WAIT_CYC - 1));

  bbp_wrap_idx u_wr_after (
    .cur (dn_id_reg),
    .lim (nw_blk),
    .nxt (wr_after_img)
  );

  bbp_wrap_idx u_wr_first (
    .cur (16'h0000),
    .lim (nw_blk),
    .nxt (wr_first)
  );

  // ------------------------------------------------------------------
  // Status counters
  // ------------------------------------------------------------------
  assign evt_all = {p1_evt, send_end && (cur_rd_reg == ID_STATUS)}; // RULE_13

  generate
    for (genvar i = 0; i < 5; i++) begin : g_cnt
      bbp_evt_cnt u_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .evt     (evt_all[i]),
        .cnt     (cnt[i])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          OFS_RD_START: prdata <= {16'h0000, rd_start_reg};
          OFS_RD_COUNT: prdata <= {16'h0000, rd_count_reg};
          OFS_WR_START: prdata <= {16'h0000, wr_start_reg};
          OFS_WR_COUNT: prdata <= {16'h0000, wr_count_reg};
          OFS_CTRL:     prdata <= {31'h0000_0000, enable_reg};
          OFS_SEQ:      prdata <= {wr_req_reg, cur_rd_reg};
          OFS_SCAN:     prdata <= {16'h0000, cnt[0]};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_start_reg <= RST_REGION;
      rd_count_reg <= RST_REGION;
      wr_start_reg <= RST_REGION;
      wr_count_reg <= RST_REGION;
      enable_reg   <= RST_ENABLE;
    end else if (psel && penable && pready && pwrite) begin
      case (paddr)
        OFS_RD_START: rd_start_reg <= pwdata[15:0];
        OFS_RD_COUNT: rd_count_reg <= pwdata[15:0];
        OFS_WR_START: wr_start_reg <= pwdata[15:0];
        OFS_WR_COUNT: wr_count_reg <= pwdata[15:0];
        OFS_CTRL:     enable_reg   <= pwdata[0];
        default:      enable_reg   <= enable_reg;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Paging sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= ST_IDLE;
      up_cnt_reg   <= 6'h00;
      wait_cnt_reg <= 12'h000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          up_cnt_reg <= 6'h00;
          if (enable_reg) begin
            state_reg <= ST_SEND; // RULE_01
          end
        end
        ST_SEND: begin
          up_cnt_reg <= up_cnt_reg + 6'h01;
          if (send_end) begin
            state_reg    <= ST_WAIT;
            wait_cnt_reg <= 12'h000;
          end
        end
        ST_WAIT: begin
          wait_cnt_reg <= wait_cnt_reg + 12'h001;
          up_cnt_reg   <= 6'h00;
          if (!enable_reg) begin
            state_reg <= ST_IDLE;
          end else if (got_img_reg || timeout) begin
            state_reg <= ST_SEND;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Null block, data blocks in order, status block, then around again
  always_comb begin
    if (cur_rd_reg == ID_STATUS) begin
      rd_next = ID_NULL; // RULE_11
    end else if (cur_rd_reg >= nr_blk) begin
      rd_next = ID_STATUS; // RULE_12
    end else begin
      rd_next = cur_rd_reg + 16'h0001; // RULE_08
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_rd_reg <= ID_NULL;
    end else if (state_reg == ST_IDLE) begin
      cur_rd_reg <= ID_NULL;
    end else if (send_end) begin
      cur_rd_reg <= rd_next;
    end
  end

  // A late host leaves the request where it was
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_req_reg <= 16'h0000;
    end else if (jump.valid) begin
      wr_req_reg <= jump.wr_id; // RULE_09
    end else if (state_reg == ST_IDLE) begin
      wr_req_reg <= wr_first;
    end else if (img_done_reg) begin
      wr_req_reg <= wr_after_img; // RULE_08 RULE_09 RULE_10
    end
  end

  // Arrival flag: a new image wins over the clear at send start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got_img_reg <= 1'b0;
    end else if (img_done_reg) begin
      got_img_reg <= 1'b1;
    end else if (state_reg == ST_SEND && up_cnt_reg == 6'h00) begin
      got_img_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Input image assembly
  // ------------------------------------------------------------------
  assign up_off  = blk_off(cur_rd_reg, 6'(up_cnt_reg - 6'(UP_PAY_LO)));
  assign up_addr = 17'(rd_start_reg) + up_off;

  always_comb begin
    up_word = 16'h0000;
    if (up_cnt_reg == 6'h00) begin
      up_word = cur_rd_reg; // RULE_04 RULE_06 RULE_22
    end else if (up_cnt_reg == 6'h01) begin
      up_word = wr_req_reg; // RULE_04
    end else if (cur_rd_reg == ID_STATUS) begin
      case (up_cnt_reg)
        SW_SCAN:   up_word = cnt[0]; // RULE_13
        SW_PROD_L: up_word = PRODUCT_CODE[15:0]; // RULE_14
        SW_PROD_H: up_word = PRODUCT_CODE[31:16];
        SW_VER_L:  up_word = SW_VERSION[15:0];
        SW_VER_H:  up_word = SW_VERSION[31:16];
        SW_OS_L:   up_word = OS_DATE[15:0];
        SW_OS_H:   up_word = OS_DATE[31:16];
        SW_RUN_L:  up_word = RUN_NUMBER[15:0];
        SW_RUN_H:  up_word = RUN_NUMBER[31:16];
        SW_P1_REQ: up_word = cnt[1]; // RULE_15
        SW_P1_RSP: up_word = cnt[2];
        SW_P1_ERR: up_word = cnt[3];
        SW_P1_TX:  up_word = cnt[4]; // RULE_16
        default:   up_word = 16'h0000;
      endcase
    end else if (cur_rd_reg != ID_NULL &&
                 up_cnt_reg >= 6'(UP_PAY_LO) &&
                 up_cnt_reg <= 6'(UP_PAY_HI) &&
                 up_off < 17'(rd_count_reg) &&
                 up_addr < 17'(DB_WORDS)) begin
      up_word = db[up_addr[DB_AW-1:0]]; // RULE_18
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up <= '0;
    end else begin
      up.valid <= (state_reg == ST_SEND);
      up.first <= (state_reg == ST_SEND) && (up_cnt_reg == 6'h00);
      up.last  <= send_end; // RULE_21
      up.idx   <= up_cnt_reg;
      up.data  <= up_word;
    end
  end

  // ------------------------------------------------------------------
  // Output image intake
  // ------------------------------------------------------------------
  assign dn_off  = blk_off(dn_id_reg, 6'(dn_idx_reg - 6'(DN_PAY_LO)));
  assign dn_addr = 17'(wr_start_reg) + dn_off;
  assign dn_wr_en = dn.valid && !dn.first && dn_live_reg &&
                    dn_idx_reg >= 6'(DN_PAY_LO) &&
                    dn_idx_reg <= 6'(DN_PAY_HI) &&
                    dn_id_reg != 16'h0000 && dn_id_reg <= nw_blk &&
                    dn_off < 17'(wr_count_reg) &&
                    dn_addr < 17'(DB_WORDS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dn_idx_reg   <= 6'h00;
      dn_live_reg  <= 1'b0;
      dn_id_reg    <= 16'h0000;
      img_done_reg <= 1'b0;
    end else begin
      img_done_reg <= 1'b0;
      if (dn.valid && dn.first) begin
        dn_id_reg   <= dn.data; // RULE_05
        dn_idx_reg  <= 6'h01;
        dn_live_reg <= 1'b1;
      end else if (dn.valid && dn_live_reg) begin
        dn_idx_reg <= dn_idx_reg + 6'h01;
        if (dn_idx_reg == 6'(IMG_WORDS-1)) begin
          dn_live_reg  <= 1'b0; // RULE_21
          img_done_reg <= 1'b1;
        end
      end
    end
  end

  // Host payload wins a same-address clash with the network
  always_ff @(posedge pclk) begin
    if (net_wr.valid && net_wr.addr < DB_AW'(DB_WORDS)) begin
      db[net_wr.addr] <= net_wr.data; // RULE_19
    end
    if (dn_wr_en) begin
      db[dn_addr[DB_AW-1:0]] <= dn.data; // RULE_07 RULE_01
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      net_rd_data <= 16'h0000;
    end else if (net_rd_addr < DB_AW'(DB_WORDS)) begin
      net_rd_data <= db[net_rd_addr]; // RULE_20
    end else begin
      net_rd_data <= 16'h0000;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_frame_length: assert property (up.first |-> ##63 up.last) // RULE_21
    else $error("input image not 64 words");
  a_word0_index: assert property (
    up.first |-> up.data == $past(cur_rd_reg)) // RULE_04
    else $error("word 0 is not the upload index");
  a_word1_request: assert property (
    up.valid && up.idx == 6'h01 |-> up.data == $past(wr_req_reg)) // RULE_04
    else $error("word 1 is not the download request");
  a_null_follows: assert property (
    send_end && cur_rd_reg == ID_STATUS |=> cur_rd_reg == ID_NULL) // RULE_11
    else $error("null block does not follow status");
  a_status_after: assert property (
    send_end && cur_rd_reg != ID_STATUS && cur_rd_reg >= nr_blk
    |=> cur_rd_reg == ID_STATUS) // RULE_12
    else $error("status block missing after last block");
  a_read_step: assert property (
    send_end && cur_rd_reg < nr_blk
    |=> cur_rd_reg == $past(cur_rd_reg) + 16'h0001) // RULE_08
    else $error("upload index did not step");
  a_late_repeat: assert property ( // RULE_10
    timeout && !jump.valid && !img_done_reg ##1 !jump.valid && !img_done_reg
    |=> ##1 up.valid && up.idx == 6'h01 &&
    up.data == $past(wr_req_reg, 3))
    else $error("late host handling broken");
  a_same_request: assert property (
    timeout && !jump.valid && !img_done_reg |=> $stable(wr_req_reg)) // RULE_10
    else $error("request changed on timeout");
  a_scan_count: assert property (
    send_end && cur_rd_reg == ID_STATUS
    |=> cnt[0] == $past(cnt[0]) + 16'h0001) // RULE_13
    else $error("scan count did not advance");
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("apb access not answered");

  c_status_sent: cover property (up.first && up.data == ID_STATUS);
  c_timeout:     cover property (timeout);
  c_host_image:  cover property (img_done_reg && dn_id_reg != wr_req_reg);
  c_null_sent:   cover property (up.first && up.data == ID_NULL);

endmodule : bbp_paging
`default_nettype wire

/* verification/bbp_host_model.sv */
// Host controller model that returns the requested output image
`default_nettype none
module bbp_host_model (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire bbp_pkg::bbp_up_t up,
  input  wire logic             host_on,
  input  wire logic [7:0]       reply_gap,
  output bbp_pkg::bbp_dn_t      dn
);
  timeunit 1ns;
  timeprecision 1ps;
  import bbp_pkg::*;
  logic [15:0] req_id;
  logic        busy;
  int          cnt;
  // Reply starts reply_gap + 2 cycles after the last word of an image
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy   <= 1'b0;
      cnt    <= 0;
      req_id <= '0;
      dn     <= '0;
    end else begin
      if (up.valid && up.idx == 6'h01) req_id <= up.data;
      if (up.valid && up.last && host_on) begin
        busy <= 1'b1;
        cnt  <= -int'(reply_gap);
      end else if (busy) begin
        cnt <= cnt + 1;
        if (cnt == 63) busy <= 1'b0;
      end
      dn.valid <= busy && cnt >= 0;
      dn.first <= busy && cnt == 0;
      // Spare words and idle time carry a toggling pattern
      if (busy && cnt == 0) dn.data <= req_id;
      else if (busy && cnt > 0 && cnt <= 60)
        dn.data <= 16'h5000 + (req_id << 8) + 16'(cnt);
      else dn.data <= ~dn.data;
    end
  end
endmodule : bbp_host_model
`default_nettype wire

/* verification/backplane_block_paging_bench.sv */
// Self-checking bench for the block paging engine
`default_nettype none
module backplane_block_paging_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import bbp_pkg::*;
  localparam logic [31:0] PCODE = 32'h0012_3456; // Arbitrary value
  localparam logic [31:0] SWVER = 32'h0002_0003;
  localparam logic [31:0] OSDAT = 32'h0001_0203;
  localparam logic [31:0] RUNNO = 32'h0000_0042;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        host_on, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  reply_gap;
  bbp_up_t     up;
  bbp_dn_t     dn;
  bbp_jump_t   jump;
  bbp_net_wr_t net_wr;
  logic [12:0] net_rd_addr;
  logic [15:0] net_rd_data, scan0, v;
  logic [3:0]  p1_evt;
  logic [15:0] img [64];
  logic [31:0] idp [4] = '{PCODE, SWVER, OSDAT, RUNNO};
  logic [15:0] eids [4] = '{ID_NULL, 16'h0001, 16'h0002, ID_STATUS};
  int          ecnt [4] = '{3, 2, 1, 4};
  int          fails = 0;
  int          compares = 0;
  int          cyc = 0;

  bbp_paging #(.PRODUCT_CODE(PCODE), .SW_VERSION(SWVER),
    .OS_DATE(OSDAT), .RUN_NUMBER(RUNNO)) bbp_paging_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .up(up),
    .dn(dn), .jump(jump), .net_wr(net_wr), .net_rd_addr(net_rd_addr),
    .net_rd_data(net_rd_data), .p1_evt(p1_evt));
  bbp_host_model bbp_host_model_inst (
    .pclk(pclk), .presetn(presetn), .up(up), .host_on(host_on),
    .reply_gap(reply_gap), .dn(dn));

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task complete_run;
    $display("counts fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      complete_run;
    end
  end

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task get_image;
    do begin
      @(posedge pclk);
    end while (!(up.valid === 1'b1 && up.first === 1'b1));
    for (int i = 0; i < 64; i++) begin
      img[i] = up.data;
      chk(up.idx, i);
      if (i < 63) @(posedge pclk);
    end
    chk(up.last, 1'b1);
  endtask : get_image

  task rd_db(input int a);
    @(posedge pclk);
    net_rd_addr <= 13'(a);
    repeat (2) @(posedge pclk);
    v = net_rd_data;
  endtask : rd_db

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task test_regs;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, OFS_RD_START + 12'(4 * i), 32'h0);
      chk(r, 32'(RST_REGION));
    end
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(r, 32'(RST_ENABLE));
    apb(1'b1, OFS_RD_COUNT, 32'hFFFF_0064);
    apb(1'b0, OFS_RD_COUNT, 32'h0);
    chk(r, 32'h0000_0064);
    apb(1'b1, 12'h01C, 32'h1);
    chk(e, 1'b1);
    apb(1'b0, 12'h01C, 32'h0);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, OFS_SCAN, 32'h5);
    chk(e, 1'b0);
    $display("test regs done");
  endtask : test_regs

  task test_setup;
    for (int a = 0; a < 120; a++) begin
      @(posedge pclk);
      net_wr <= '{1'b1, 13'(a), 16'hA000 + 16'(a)};
    end
    @(posedge pclk);
    net_wr <= '{1'b1, 13'h012C, 16'h1234};
    @(posedge pclk);
    net_wr <= '0;
    for (int j = 0; j < 4; j++) begin
      repeat (ecnt[j]) begin
        @(posedge pclk);
        p1_evt <= 4'h1 << j;
        @(posedge pclk);
        p1_evt <= 4'h0;
      end
    end
    apb(1'b1, OFS_WR_START, 32'h0000_00C8);
    apb(1'b1, OFS_WR_COUNT, 32'h0000_0064);
    apb(1'b1, OFS_CTRL, 32'h1);
    $display("test setup done");
  endtask : test_setup

  task test_cycle;
    int a;
    for (int n = 0; n < 8; n++) begin
      get_image;
      if (n == 3) reply_gap <= 8'd90;
      chk(img[0], eids[n % 4]);
      chk(img[1], n % 2 + 1);
      chk({img[62], img[63]}, 32'h0);
      if (n % 4 == 1 || n % 4 == 2) begin
        for (int i = 0; i < 60; i++) begin
          a = (n % 4 - 1) * 60 + i;
          chk(img[2 + i], a < 100 ? 16'hA000 + 16'(a) : 16'h0);
        end
      end
      if (n % 4 == 3) begin
        if (n == 7) chk(img[2], scan0 + 16'h1);
        scan0 = img[2];
        for (int j = 0; j < 4; j++) begin
          chk({img[4 + 2 * j], img[3 + 2 * j]}, idp[j]);
          chk(img[11 + j], ecnt[j]);
        end
      end
    end
    host_on <= 1'b0;
    for (int id = 1; id < 3; id++) begin
      rd_db(200 + (id - 1) * 60);
      chk(v, 16'h5001 + 16'(id << 8));
      rd_db(199 + (id - 1) * 60 + (id == 1 ? 60 : 40));
      chk(v, 16'h5000 + 16'(id << 8) + (id == 1 ? 16'd60 : 16'd40));
    end
    rd_db(300);
    chk(v, 16'h1234);
    $display("test cycle done");
  endtask : test_cycle

  task test_timeout;
    get_image;
    chk({img[0], img[1]}, 32'h0000_0001);
    get_image;
    chk({img[0], img[1]}, 32'h0001_0001);
    @(posedge pclk);
    jump <= '{1'b1, 16'h0002};
    @(posedge pclk);
    jump <= '0;
    get_image;
    chk({img[0], img[1]}, 32'h0002_0002);
    apb(1'b0, OFS_SEQ, 32'h0);
    chk(r, 32'h0002_FFFF);
    apb(1'b0, OFS_SCAN, 32'h0);
    chk(r, {16'h0000, scan0 + 16'h0001});
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, OFS_SEQ, 32'h0);
    chk(r, 32'h0001_0000);
    $display("test timeout done");
  endtask : test_timeout

  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = '0;
    pwdata      = '0;
    jump        = '0;
    net_wr      = '0;
    net_rd_addr = '0;
    p1_evt      = '0;
    host_on     = 1'b1;
    reply_gap   = 8'd2;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_regs;
    test_setup;
    test_cycle;
    test_timeout;
    complete_run;
  end
endmodule : backplane_block_paging_bench
`default_nettype wire
